/* File: hw/sfr_pkg.sv */
//Operation
//RL1 - Reset needs arming command then reset next
//RL2 - Other command after arming cancels the arming
//RL3 - Accepted reset aborts operations, restores power-on state
//RL4 - Accepted reset clears every volatile setting
//RL5 - About 30us of reset ignores all commands
//RL6 - Host should check busy and suspend first
//RL7 - Write-in-progress high only during self-timed operation
//RL8 - Suspend flag set while suspended; resume needs it
//RL9 - Command acts at select release after eight bits
package sfr_pkg;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int CLK_PERIOD_NS = 50;
   localparam int RESET_TIME_NS = 30000;
   localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ERASE_TIME_MS = 500;
   localparam int ERASE_CYCLES = ERASE_TIME_MS * (1000000 / CLK_PERIOD_NS);
   localparam int RST_CNT_W = 10;
   localparam int OP_CNT_W = 24;
   localparam int BIT_CNT_W = 4;
   localparam logic [BIT_CNT_W-1:0] CMD_BITS = 4'h8;
   localparam logic [BIT_CNT_W-1:0] BITS_OVER = 4'h9;

   // ************************************************************
   // Command codes
   // ************************************************************
   localparam logic [7:0] OP_ENABLE_RESET = 8'h7e;
   localparam logic [7:0] OP_RESET = 8'h99;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_ERASE_A = 8'h60;
   localparam logic [7:0] OP_ERASE_B = 8'hc7;
   localparam logic [7:0] OP_SUSPEND = 8'h75;
   localparam logic [7:0] OP_RESUME = 8'h7a;

   // ************************************************************
   // Register port map and fields
   // ************************************************************
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_STATUS = 8'h00;
   localparam logic [ADDR_W-1:0] REG_VCFG = 8'h04;
   localparam int ST_RUNNING_BIT = 0;
   localparam int ST_LATCH_BIT = 1;
   localparam int ST_SUSPEND_BIT = 2;
   localparam int ST_ARMED_BIT = 3;
   localparam int ST_RST_BIT = 4;
   localparam int VCFG_VOL_LSB = 0;
   localparam int VCFG_CRB_LSB = 8;
   localparam int VCFG_WRAP_LSB = 16;
   localparam logic [7:0] VOL_RST = 8'h00;
   localparam logic [7:0] CRB_RST = 8'h00;
   localparam logic [2:0] WRAP_RST = 3'h0;

   // ************************************************************
   // Types
   // ************************************************************
   typedef enum logic [1:0] {SFR_READY, SFR_ARMED, SFR_RESETTING} sfr_mode_type;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic mosi;
   } sfr_spi_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } sfr_bus_type;

   typedef struct packed {
      sfr_mode_type mode;
      logic sclk_prev;
      logic cs_prev;
      logic [7:0] shift;
      logic [BIT_CNT_W-1:0] bitcnt;
      logic [RST_CNT_W-1:0] rst_cnt;
      logic [OP_CNT_W-1:0] op_cnt;
      logic write_in_progress;
      logic suspend_flag;
      logic write_enable_latch;
      logic [7:0] vol_status;
      logic [7:0] continuous_read_byte;
      logic [2:0] wrap_length_field;
      logic [31:0] rd_data;
   } sfr_state_type;

   localparam sfr_state_type STATE_RST = '{mode: SFR_READY, cs_prev: 1'b1, vol_status: VOL_RST,
      continuous_read_byte: CRB_RST, wrap_length_field: WRAP_RST, default: '0};

endpackage

/* File: hw/sfr_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser; stage one feeds stage two only
module sfr_sync #(
   parameter int WIDTH = 3,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // ************************************************************
   // Capture stages
   // ************************************************************
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         meta_q <= INIT;
         sync_q <= INIT;
      end else begin
         meta_q <= i_async;
         sync_q <= meta_q;
      end
   end

   assign o_sync = sync_q;
endmodule

/* File: hw/sfr_core.sv */
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/1ps
module sfr_core #(
   parameter int P_ERASE_CYCLES = sfr_pkg::ERASE_CYCLES
) (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire sfr_pkg::sfr_spi_type i_spi,
   input wire sfr_pkg::sfr_bus_type i_bus,
   output logic [31:0] o_rd_data,
   output logic o_reset_busy,
   output logic o_write_in_progress
);
   sfr_pkg::sfr_state_type q;
   sfr_pkg::sfr_state_type d;
   sfr_pkg::sfr_spi_type spi_s;
   logic cmd_done;
   logic reset_accept;
   logic vcfg_wr;
   logic [sfr_pkg::RST_CNT_W-1:0] busy_run_q;

   // Erase count must fit the operation timer
   if (P_ERASE_CYCLES < 2 || P_ERASE_CYCLES >= (1 << sfr_pkg::OP_CNT_W)) begin : g_bad_erase
      $error("P_ERASE_CYCLES out of range");
   end

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   // Pins are sampled, so serial clock must stay below a quarter of the reference
   sfr_sync #(.WIDTH(3), .INIT(3'h4)) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_srst(i_srst),
      .i_async(i_spi),
      .o_sync(spi_s)
   );

   // Select released after exactly eight bits
   assign cmd_done = spi_s.cs_n && !q.cs_prev && q.bitcnt == sfr_pkg::CMD_BITS; // RL9
   assign reset_accept = cmd_done && q.shift == sfr_pkg::OP_RESET && q.mode == sfr_pkg::SFR_ARMED; // RL1
   // Settings writes lose to an accepted reset so the cleared values are not overwritten
   assign vcfg_wr = i_bus.wr && i_bus.addr == sfr_pkg::REG_VCFG // RL5
      && q.mode != sfr_pkg::SFR_RESETTING && !reset_accept;

   // Both erase codes start the same self-timed cycle
   function automatic logic is_erase(input logic [7:0] op);
      return op == sfr_pkg::OP_ERASE_A || op == sfr_pkg::OP_ERASE_B;
   endfunction

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      d = q;
      d.sclk_prev = spi_s.sclk;
      d.cs_prev = spi_s.cs_n;
      d.rd_data = '0;
      // Shift on rising serial clock inside a frame; count saturates past eight
      if (spi_s.cs_n) begin
         d.bitcnt = '0;
      end else if (spi_s.sclk && !q.sclk_prev) begin
         d.shift = {q.shift[6:0], spi_s.mosi};
         if (q.bitcnt != sfr_pkg::BITS_OVER) begin
            d.bitcnt = q.bitcnt + 4'h1;
         end
      end
      // Self-timed erase; the latch drops as it completes
      if (q.write_in_progress) begin
         d.op_cnt = q.op_cnt - 24'h1;
         if (q.op_cnt == 24'h1) begin
            d.write_in_progress = 1'b0; // RL7
            d.write_enable_latch = 1'b0;
         end
      end
      // Reset interval runs out
      if (q.mode == sfr_pkg::SFR_RESETTING) begin
         d.rst_cnt = q.rst_cnt - 10'h1;
         if (q.rst_cnt == 10'h1) begin
            d.mode = sfr_pkg::SFR_READY;
         end
      end
      // Commands; nothing is taken while the reset interval runs
      if (cmd_done && q.mode != sfr_pkg::SFR_RESETTING) begin // RL5
         d.mode = sfr_pkg::SFR_READY; // RL2
         case (q.shift)
            sfr_pkg::OP_ENABLE_RESET: begin
               d.mode = sfr_pkg::SFR_ARMED; // RL1
            end
            sfr_pkg::OP_RESET: begin
               if (reset_accept) begin
                  d = sfr_pkg::STATE_RST; // RL3 RL4
                  d.sclk_prev = spi_s.sclk;
                  d.cs_prev = spi_s.cs_n;
                  d.mode = sfr_pkg::SFR_RESETTING;
                  d.rst_cnt = sfr_pkg::RST_CNT_W'(sfr_pkg::RESET_CYCLES); // RL5
               end
            end
            sfr_pkg::OP_WRITE_ENABLE: begin
               if (!q.write_in_progress) begin
                  d.write_enable_latch = 1'b1;
               end
            end
            sfr_pkg::OP_WRITE_DISABLE: begin
               if (!q.write_in_progress) begin
                  d.write_enable_latch = 1'b0;
               end
            end
            sfr_pkg::OP_ERASE_A, sfr_pkg::OP_ERASE_B: begin
               if (q.write_enable_latch && !q.write_in_progress && !q.suspend_flag) begin
                  d.write_in_progress = 1'b1; // RL7
                  d.op_cnt = sfr_pkg::OP_CNT_W'(P_ERASE_CYCLES);
               end
            end
            sfr_pkg::OP_SUSPEND: begin
               if (q.write_in_progress) begin
                  d.write_in_progress = 1'b0;
                  d.suspend_flag = 1'b1; // RL8
               end
            end
            sfr_pkg::OP_RESUME: begin
               if (q.suspend_flag && !q.write_in_progress) begin // RL8
                  d.suspend_flag = 1'b0;
                  d.write_in_progress = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // Volatile settings port; locked while resetting
      if (vcfg_wr) begin
         d.vol_status = i_bus.wdata[sfr_pkg::VCFG_VOL_LSB +: 8];
         d.continuous_read_byte = i_bus.wdata[sfr_pkg::VCFG_CRB_LSB +: 8];
         d.wrap_length_field = i_bus.wdata[sfr_pkg::VCFG_WRAP_LSB +: 3];
      end
      // Read data appears in the following cycle only; unmapped reads give zero
      if (i_bus.rd) begin
         if (i_bus.addr == sfr_pkg::REG_STATUS) begin
            d.rd_data[sfr_pkg::ST_RUNNING_BIT] = q.write_in_progress;
            d.rd_data[sfr_pkg::ST_LATCH_BIT] = q.write_enable_latch;
            d.rd_data[sfr_pkg::ST_SUSPEND_BIT] = q.suspend_flag;
            d.rd_data[sfr_pkg::ST_ARMED_BIT] = q.mode == sfr_pkg::SFR_ARMED;
            d.rd_data[sfr_pkg::ST_RST_BIT] = q.mode == sfr_pkg::SFR_RESETTING;
         end else if (i_bus.addr == sfr_pkg::REG_VCFG) begin
            d.rd_data[sfr_pkg::VCFG_VOL_LSB +: 8] = q.vol_status;
            d.rd_data[sfr_pkg::VCFG_CRB_LSB +: 8] = q.continuous_read_byte;
            d.rd_data[sfr_pkg::VCFG_WRAP_LSB +: 3] = q.wrap_length_field;
         end
      end
      if (i_srst) begin
         d = sfr_pkg::STATE_RST;
      end
   end

   // State register
   always_ff @(posedge i_ref_clk) begin
      q <= d;
   end

   assign o_rd_data = q.rd_data;
   assign o_reset_busy = q.mode == sfr_pkg::SFR_RESETTING;
   assign o_write_in_progress = q.write_in_progress;

   // ************************************************************
   // Assertion helpers
   // ************************************************************
   // Counts busy cycles so the interval length is checked without a long delay chain
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || !o_reset_busy) begin
         busy_run_q <= '0;
      end else begin
         busy_run_q <= busy_run_q + 10'h1;
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   // Arming and the reset that follows it; a repeated arming command arms afresh
   arm_then_reset_a: assert property (reset_accept |=> o_reset_busy) else $error("armed reset not taken"); // RL1
   reset_needs_arm_a: assert property ($rose(o_reset_busy) |-> $past(reset_accept)) else $error("reset unarmed"); // RL1
   other_disarms_a: assert property (cmd_done && q.mode == sfr_pkg::SFR_ARMED && q.shift != sfr_pkg::OP_RESET // RL2
      && q.shift != sfr_pkg::OP_ENABLE_RESET |=> q.mode == sfr_pkg::SFR_READY) else $error("arming kept");
   abort_ops_a: assert property (reset_accept |=> !q.write_in_progress && !q.suspend_flag // RL3
      && q.op_cnt == '0) else $error("operation not aborted");
   clear_volatile_a: assert property (reset_accept |=> !q.write_enable_latch && q.continuous_read_byte == '0 // RL4
      && q.wrap_length_field == '0 && q.vol_status == '0) else $error("volatile kept");

   // Reset interval: its length and what it locks out
   reset_load_a: assert property (reset_accept |=> q.rst_cnt == sfr_pkg::RST_CNT_W'(sfr_pkg::RESET_CYCLES)) // RL5
      else $error("reset count not loaded");
   reset_length_a: assert property ($fell(o_reset_busy) // RL5
      |-> busy_run_q == sfr_pkg::RST_CNT_W'(sfr_pkg::RESET_CYCLES)) else $error("reset length wrong");
   vcfg_locked_a: assert property (o_reset_busy && i_bus.wr |=> $stable(q.vol_status) // RL5
      && $stable(q.continuous_read_byte) && $stable(q.wrap_length_field)) else $error("settings written in reset");
   ignore_during_a: assert property (o_reset_busy && cmd_done && q.shift == sfr_pkg::OP_WRITE_ENABLE // RL5
      |=> !q.write_enable_latch) else $error("command taken in reset");

   // Self-timed erase, suspend and resume
   erase_start_a: assert property (cmd_done && is_erase(q.shift) && q.write_enable_latch && !o_reset_busy // RL7
      && !q.write_in_progress && !q.suspend_flag |=> q.write_in_progress
      && q.op_cnt == sfr_pkg::OP_CNT_W'(P_ERASE_CYCLES)) else $error("erase not started");
   erase_needs_latch_a: assert property (cmd_done && is_erase(q.shift) && !q.write_enable_latch // RL7
      && !q.write_in_progress |=> !q.write_in_progress) else $error("erase without latch");
   erase_end_a: assert property (q.write_in_progress && q.op_cnt == 24'h1 |=> !q.write_in_progress // RL7
      && !q.write_enable_latch) else $error("erase did not end");
   suspend_excl_a: assert property (!(q.suspend_flag && q.write_in_progress)) // RL8
      else $error("suspended while running");
   resume_rule_a: assert property (cmd_done && q.shift == sfr_pkg::OP_RESUME && !o_reset_busy // RL8
      && !(q.suspend_flag && !q.write_in_progress) |=> $stable(q.suspend_flag)) else $error("bad resume");

   // Frames of the wrong length leave the mode alone
   short_frame_a: assert property ($rose(spi_s.cs_n) && q.bitcnt != sfr_pkg::CMD_BITS && !o_reset_busy // RL9
      |=> q.mode == $past(q.mode)) else $error("partial frame acted");

   // Main scenarios reached
   reset_seen_c: cover property (reset_accept ##1 o_reset_busy [*8]);
   disarm_seen_c: cover property (q.mode == sfr_pkg::SFR_ARMED ##1 q.mode == sfr_pkg::SFR_READY);
   suspend_seen_c: cover property ($rose(q.suspend_flag));
   resume_seen_c: cover property ($fell(q.suspend_flag) && q.write_in_progress);
   erase_done_c: cover property ($fell(q.write_in_progress) && !q.suspend_flag);
endmodule

/* File: testbench/sfr_host.sv */
`timescale 1ns/1ps
// Host controller model; sclk rests low and cs high between frames
module sfr_host (
   input wire logic i_ref_clk,
   output sfr_pkg::sfr_spi_type o_spi
);
   initial begin
      o_spi = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
   end
   task automatic hold(input int n);
      repeat (n) @(posedge i_ref_clk);
   endtask
   // One frame MSB first; half bits of four cycles so the 2-FF sampler sees each edge
   task automatic send(input logic [7:0] op, input int nbits);
      @(posedge i_ref_clk);
      o_spi.cs_n <= 1'b0;
      for (int i = 0; i < nbits; i++) begin
         o_spi.mosi <= op[3'(7 - (i % 8))];
         hold(4);
         o_spi.sclk <= 1'b1;
         hold(4);
         o_spi.sclk <= 1'b0;
      end
      hold(4);
      o_spi.cs_n <= 1'b1;
      o_spi.mosi <= ~o_spi.mosi; // Released line shows no stale bit
      hold(10);
   endtask
endmodule

/* File: testbench/spi_flash_soft_reset_test.sv */
`timescale 1ns/1ps
module spi_flash_soft_reset_test;
   localparam int ERASE_N = 400;
   localparam logic [7:0] ST = sfr_pkg::REG_STATUS;
   localparam logic [7:0] VC = sfr_pkg::REG_VCFG;
   logic i_ref_clk;
   logic i_srst;
   sfr_pkg::sfr_spi_type spi;
   sfr_pkg::sfr_bus_type bus;
   logic [31:0] rd_data;
   logic reset_busy;
   logic op_busy;
   logic [31:0] got;
   int err_count;
   int num_checks;
   int busy_len;

   sfr_host u_host (.i_ref_clk(i_ref_clk), .o_spi(spi));
   sfr_core #(.P_ERASE_CYCLES(ERASE_N)) u_dut (.i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_spi(spi),
      .i_bus(bus), .o_rd_data(rd_data), .o_reset_busy(reset_busy), .o_write_in_progress(op_busy));

   // ************************************************************
   // Clock, busy length monitor
   // ************************************************************
   initial begin
      i_ref_clk = 1'b0;
      forever #25 i_ref_clk = ~i_ref_clk;
   end
   always @(posedge i_ref_clk) begin
      busy_len <= (reset_busy === 1'b1) ? busy_len + 1 : busy_len;
   end

   // ************************************************************
   // Access tasks
   // ************************************************************
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      @(posedge i_ref_clk);
      bus.wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge i_ref_clk);
      bus.addr <= a;
      bus.rd <= 1'b1;
      @(posedge i_ref_clk);
      bus.rd <= 1'b0;
      @(negedge i_ref_clk);
      got = rd_data;
      chk(got, e);
   endtask
   // Bounded wait so a stuck busy flag cannot hang the run
   task automatic settle();
      for (int i = 0; i < 1000 && (reset_busy !== 1'b0 || op_busy !== 1'b0); i++) begin
         @(posedge i_ref_clk);
      end
      chk({30'h0, reset_busy, op_busy}, 32'h0);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      // Watchdog: the whole run needs well under 10000 cycles
      #1000000;
      err_count++;
      report_and_stop();
   end
   initial begin
      bus = '0;
      busy_len = 0;
      err_count = 0;
      num_checks = 0;
      i_srst = 1'b1;
      repeat (5) @(posedge i_ref_clk);
      i_srst <= 1'b0;
      repeat (4) @(posedge i_ref_clk);
      rchk(ST, 32'h0);
      rchk(VC, 32'h0);
      rchk(8'h08, 32'h0);
      wr(ST, 32'hffffffff);
      rchk(ST, 32'h0);
      $display("test defaults done");
      wr(VC, 32'h0007ff5a);
      rchk(VC, 32'h0007ff5a);
      u_host.send(8'h06, 8);
      u_host.send(8'h7e, 8);
      rchk(ST, 32'h0a);
      u_host.send(8'h04, 8);
      u_host.send(8'h99, 8);
      rchk(ST, 32'h0);
      rchk(VC, 32'h0007ff5a);
      $display("test disarm done");
      u_host.send(8'h7e, 7);
      rchk(ST, 32'h0);
      u_host.send(8'h7e, 8);
      u_host.send(8'h99, 9);
      rchk(ST, 32'h08);
      busy_len = 0;
      u_host.send(8'h99, 8);
      chk({31'h0, reset_busy}, 32'h1);
      rchk(ST, 32'h10);
      rchk(VC, 32'h0);
      u_host.send(8'h06, 8);
      u_host.send(8'h7e, 8);
      wr(VC, 32'h5a);
      settle();
      chk(32'(busy_len), 32'd600);
      rchk(ST, 32'h0);
      rchk(VC, 32'h0);
      $display("test reset done");
      wr(VC, 32'h0007ff5a);
      u_host.send(8'h06, 8);
      u_host.send(8'h60, 8);
      rchk(ST, 32'h03);
      u_host.send(8'h75, 8);
      rchk(ST, 32'h06);
      chk({31'h0, op_busy}, 32'h0);
      u_host.send(8'h7a, 8);
      rchk(ST, 32'h03);
      u_host.send(8'h75, 8);
      u_host.send(8'h7e, 8);
      u_host.send(8'h99, 8);
      rchk(ST, 32'h10);
      rchk(VC, 32'h0);
      settle();
      rchk(ST, 32'h0);
      $display("test abort done");
      u_host.send(8'h60, 8);
      rchk(ST, 32'h0);
      u_host.send(8'h06, 8);
      u_host.send(8'hc7, 8);
      chk({31'h0, op_busy}, 32'h1);
      u_host.send(8'h04, 8);
      rchk(ST, 32'h03);
      settle();
      rchk(ST, 32'h0);
      u_host.send(8'h7a, 8);
      rchk(ST, 32'h0);
      $display("test erase done");
      report_and_stop();
   end
endmodule
